// [core/uafc_defines.svh]
// constants for the automatic flow-control block of one serial channel
// assumes a 16x sampling clock and a receive fifo level supplied from outside
// Functional notes
// - auto rts runs only while enhanced function bit 6 is set.
// - rts# rises at next higher trigger level, falls at next lower level.
// - receiver keeps storing characters while rts# is high, until fifo full.
// - rts# rising in auto mode sets status bit 5 when enable bit 6 set.
// - receive data interrupt fires at the programmed trigger level regardless of rts#.
// - tables a-c use neighbouring entries as limits; table d uses programmed hysteresis.
// - auto cts runs only while enhanced function bit 7 is set.
// - cts# high stops transmitter after the current stop bit; low resumes it.
// - cts# rising in auto mode sets status bit 5 when enable bit 7 set.
// - received stop characters halt transmission after the current character.
// - stop match sets stop flag and interrupt when enable bit 5 set.
// - resume characters restart transmission and clear status bit 4.
// - reset clears all four flow-control character registers to zero.
// - double mode needs two consecutive received characters matching the pair.
// - consumed flow-control characters are not written into the receive fifo; the code writes them while enhanced function bit 5 is set.
// - stop characters sent two character times after fifo crosses trigger.
// - resume characters sent when fifo falls below the lower limit.
// - special detect: match second stop value, store character, set status bit 4.
// - comparisons use only the selected word length, bit 0 first received.
// - rs485 mode drives rts# high after the last stop bit.
// - rs485 mode drives rts# low before the first start bit.
`ifndef UAFC_DEFINES_SVH
`define UAFC_DEFINES_SVH
`define UAFC_ENH_SPECIAL   5
`define UAFC_ENH_ENABLE    4
`define UAFC_ENH_AUTO_RTS  6
`define UAFC_ENH_AUTO_CTS  7
`define UAFC_IEN_XOFF      5
`define UAFC_IEN_RTS       6
`define UAFC_IEN_CTS       7
`define UAFC_MODEM_RTS     1
`define UAFC_FEAT_RS485    3
`define UAFC_STAT_XOFF     4
`define UAFC_STAT_RTSCTS   5
`define UAFC_CHAR_RST      8'h00
`define UAFC_BIT_CLKS      16
`define UAFC_FIFO_DEPTH    4
`endif

// [core/uafc_pkg.sv]
// types for the automatic flow-control block
// assumes nothing beyond the defines header
package uafc_pkg;
  typedef enum logic [1:0] {UAFC_SW_NONE, UAFC_SW_SINGLE, UAFC_SW_DOUBLE} uafc_swmode_t;
  typedef struct packed {
    logic [7:0] stop_first;
    logic [7:0] stop_second;
    logic [7:0] resume_first;
    logic [7:0] resume_second;
  } uafc_chars_t;
  typedef struct packed {
    logic [7:0] lower;
    logic [7:0] trigger;
    logic [7:0] upper;
  } uafc_levels_t;
endpackage : uafc_pkg

// [core/uafc_fifo.sv]
// small receive-side fifo between the character filter and the receive fifo
// assumes one clock and active-low asynchronous reset
module uafc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,    // clock
  input  wire logic             rst_n_i,  // reset
  input  wire logic             s_valid_i,// write valid
  output logic                  s_ready_o,// not full
  input  wire logic [WIDTH-1:0] s_data_i, // write data
  output logic                  m_valid_o,// not empty
  input  wire logic             m_ready_i,// read ready
  output logic      [WIDTH-1:0] m_data_o  // read data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;
  assign s_ready_o = (cnt_ff != (AW+1)'(DEPTH));
  assign m_valid_o = (cnt_ff != '0);
  assign push      = s_valid_i && s_ready_o;
  assign pop       = m_valid_o && m_ready_i;
  assign m_data_o  = mem_ff[rd_ff];
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= s_data_i;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : uafc_fifo

// [core/uafc_top.sv]
// auto rts/cts, auto xon/xoff, special character detect and rs485 direction
// assumes receiver and transmitter cores outside; fifo level and limits given as inputs
`include "uafc_defines.svh"
module uafc_top
  import uafc_pkg::*;
#(
  parameter int BIT_CLKS = `UAFC_BIT_CLKS
) (
  input  wire logic         clk_i,             // 16x sampling clock
  input  wire logic         rst_n_i,           // async reset
  input  wire logic [7:0]   enhanced_function_reg_i, // enhanced function bits
  input  wire logic [7:0]   interrupt_enable_reg_i,  // interrupt enables
  input  wire logic [7:0]   modem_control_reg_i,     // modem control bits
  input  wire logic [7:0]   feature_control_reg_i,   // feature control bits
  input  wire logic [1:0]   word_len_i,        // line control bits 0-1
  input  wire uafc_swmode_t rx_sw_mode_i,      // receive stop/resume matching
  input  wire uafc_swmode_t tx_sw_mode_i,      // automatic stop/resume sending
  input  wire logic         chars_we_i,        // write character registers
  input  wire uafc_chars_t  chars_i,           // new character values
  output uafc_chars_t       chars_o,           // character registers
  input  wire uafc_levels_t levels_i,          // lower, trigger, upper limits
  input  wire logic [7:0]   rx_level_i,        // receive fifo fill level
  input  wire logic         rx_fifo_full_i,    // receive fifo full
  input  wire logic         rx_valid_i,        // received character strobe
  input  wire logic [7:0]   rx_char_i,         // received character
  output logic              rx_ready_o,        // filter can take a character
  output logic              rxf_valid_o,       // character for receive fifo
  input  wire logic         rxf_ready_i,       // receive fifo accepts
  output logic [7:0]        rxf_data_o,        // character for receive fifo
  output logic              rx_data_irq_o,     // receive data interrupt
  input  wire logic         cts_n_i,           // clear to send, low active
  output logic              rts_n_o,           // request to send, low active
  input  wire logic         tx_data_avail_i,   // transmit fifo not empty
  input  wire logic         tx_idle_i,         // shift register empty, after stop bit
  output logic              tx_go_o,           // may load next data character
  output logic              tx_flow_valid_o,   // flow character to send
  output logic [7:0]        tx_flow_char_o,    // flow character value
  input  wire logic         tx_flow_ack_i,     // flow character loaded
  output logic              stop_flag_o,       // transmit halted by stop chars
  output logic [7:0]        interrupt_status_reg_o, // status bits 4 and 5
  output logic              irq_o              // interrupt output
);
  localparam int CHAR_CLKS = 10 * BIT_CLKS;
  localparam int WAIT_CLKS = 2 * CHAR_CLKS;

  uafc_chars_t chars_ff;
  logic        rts_hw_ff;
  logic        rts485_ff;
  logic        cts_ff;
  logic        xoff_ff;
  logic        first_hit_ff;
  logic        first_resume_ff;
  logic        special_ff;
  logic        rtscts_ff;
  logic        remote_off_ff;
  logic        send_off_ff;
  logic        send_on_ff;
  logic        tx_second_ff;
  logic [15:0] wait_ff;
  logic [7:0]  mask;
  logic        auto_rts;
  logic        auto_cts;
  logic        enh;
  logic        take;
  logic        m_stop1;
  logic        m_stop2;
  logic        m_res1;
  logic        m_res2;
  logic        consume;
  logic        stop_hit;
  logic        resume_hit;
  logic        f_valid;
  logic        f_ready;

  assign auto_rts = enhanced_function_reg_i[`UAFC_ENH_AUTO_RTS];
  assign auto_cts = enhanced_function_reg_i[`UAFC_ENH_AUTO_CTS];
  assign enh      = enhanced_function_reg_i[`UAFC_ENH_ENABLE];
  assign chars_o  = chars_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chars_ff <= {4{`UAFC_CHAR_RST}};
    end else if (chars_we_i) begin
      chars_ff <= chars_i;
    end
  end

  // word-length mask, bit 0 is the first received bit
  always_comb begin
    unique case (word_len_i)
      2'd0: mask = 8'h1f;
      2'd1: mask = 8'h3f;
      2'd2: mask = 8'h7f;
      2'd3: mask = 8'hff;
    endcase
  end

  // receive character matching
  assign take    = rx_valid_i && rx_ready_o;
  assign m_stop1 = ((rx_char_i ^ chars_ff.stop_first) & mask) == 8'h00;
  assign m_stop2 = ((rx_char_i ^ chars_ff.stop_second) & mask) == 8'h00;
  assign m_res1  = ((rx_char_i ^ chars_ff.resume_first) & mask) == 8'h00;
  assign m_res2  = ((rx_char_i ^ chars_ff.resume_second) & mask) == 8'h00;

  always_comb begin
    stop_hit   = 1'b0;
    resume_hit = 1'b0;
    consume    = 1'b0;
    unique case (rx_sw_mode_i)
      UAFC_SW_SINGLE: begin
        stop_hit   = m_stop1;
        resume_hit = m_res1 && xoff_ff;
        consume    = m_stop1 || m_res1;
      end
      UAFC_SW_DOUBLE: begin
        stop_hit   = first_hit_ff && m_stop2;
        resume_hit = first_resume_ff && m_res2 && xoff_ff;
        consume    = m_stop1 || m_res1 || (first_hit_ff && m_stop2) || (first_resume_ff && m_res2);
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_hit_ff    <= 1'b0;
      first_resume_ff <= 1'b0;
    end else if (take) begin
      first_hit_ff    <= m_stop1 && !first_hit_ff;
      first_resume_ff <= m_res1 && !first_resume_ff;
    end
  end

  // stop flag: halt after current character, resume on match
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xoff_ff <= 1'b0;
    end else if (take && stop_hit) begin
      xoff_ff <= 1'b1;
    end else if (take && resume_hit) begin
      xoff_ff <= 1'b0;
    end
  end
  assign stop_flag_o = xoff_ff;

  // special character: stored and flagged
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      special_ff <= 1'b0;
    end else if (take && enhanced_function_reg_i[`UAFC_ENH_SPECIAL] && m_stop2) begin
      special_ff <= 1'b1;
    end else if (take && resume_hit) begin
      special_ff <= 1'b0;
    end
  end

  // flow characters are dropped unless enhanced function bit 5 is set, others pass to the buffer
  assign f_valid = rx_valid_i && !(consume && !enhanced_function_reg_i[`UAFC_ENH_SPECIAL]);
  assign rx_ready_o = f_ready || (consume && !enhanced_function_reg_i[`UAFC_ENH_SPECIAL]);

  uafc_fifo #(
    .WIDTH (8),
    .DEPTH (`UAFC_FIFO_DEPTH)
  ) u_fifo (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .s_valid_i (f_valid),
    .s_ready_o (f_ready),
    .s_data_i  (rx_char_i),
    .m_valid_o (rxf_valid_o),
    .m_ready_i (rxf_ready_i && !rx_fifo_full_i),
    .m_data_o  (rxf_data_o)
  );

  assign rx_data_irq_o = (rx_level_i >= levels_i.trigger);

  // hardware rts with hysteresis limits
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rts_hw_ff <= 1'b0;
    end else if (!auto_rts) begin
      rts_hw_ff <= 1'b0;
    end else if (rx_level_i >= levels_i.upper) begin
      rts_hw_ff <= 1'b1;
    end else if (rx_level_i <= levels_i.lower) begin
      rts_hw_ff <= 1'b0;
    end
  end

  // rs485 direction: high after last stop bit, low before first start bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rts485_ff <= 1'b1;
    end else if (tx_data_avail_i || tx_flow_valid_o) begin
      rts485_ff <= 1'b0;
    end else if (tx_idle_i) begin
      rts485_ff <= 1'b1;
    end
  end

  always_comb begin
    if (feature_control_reg_i[`UAFC_FEAT_RS485]) begin
      rts_n_o = rts485_ff;
    end else begin
      rts_n_o = !modem_control_reg_i[`UAFC_MODEM_RTS] || (auto_rts && rts_hw_ff);
    end
  end

  // cts edge and status bit 5
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cts_ff <= 1'b1;  // idle level of the pin, no false edge
    end else begin
      cts_ff <= cts_n_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rtscts_ff <= 1'b0;
    end else if (auto_rts && enh && interrupt_enable_reg_i[`UAFC_IEN_RTS] &&
                 rts_hw_ff && modem_control_reg_i[`UAFC_MODEM_RTS]) begin
      rtscts_ff <= 1'b1;
    end else if (auto_cts && enh && interrupt_enable_reg_i[`UAFC_IEN_CTS] && cts_n_i && !cts_ff) begin
      rtscts_ff <= 1'b1;
    end else if (!cts_n_i && !rts_hw_ff) begin
      rtscts_ff <= 1'b0;
    end
  end

  // automatic stop/resume sending
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remote_off_ff <= 1'b0;
      send_off_ff   <= 1'b0;
      send_on_ff    <= 1'b0;
      wait_ff       <= '0;
    end else if (tx_sw_mode_i == UAFC_SW_NONE) begin
      remote_off_ff <= 1'b0;
      send_off_ff   <= 1'b0;
      send_on_ff    <= 1'b0;
      wait_ff       <= '0;
    end else begin
      // clear first so a new request in the same cycle wins
      if (tx_flow_ack_i && tx_flow_valid_o && (tx_sw_mode_i != UAFC_SW_DOUBLE || tx_second_ff)) begin
        send_off_ff <= 1'b0;
        send_on_ff  <= 1'b0;
      end
      if (!remote_off_ff && rx_level_i >= levels_i.trigger && !send_off_ff) begin
        if (wait_ff == 16'(WAIT_CLKS - 1)) begin
          send_off_ff   <= 1'b1;
          remote_off_ff <= 1'b1;
          wait_ff       <= '0;
        end else begin
          wait_ff <= wait_ff + 16'd1;
        end
      end else begin
        wait_ff <= '0;
      end
      if (remote_off_ff && !send_off_ff && rx_level_i < levels_i.lower) begin
        send_on_ff    <= 1'b1;
        remote_off_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_second_ff <= 1'b0;
    end else if (tx_flow_ack_i && tx_flow_valid_o) begin
      tx_second_ff <= (tx_sw_mode_i == UAFC_SW_DOUBLE) && !tx_second_ff;
    end
  end

  // flow characters wait for the shift register to be idle
  assign tx_flow_valid_o = (send_off_ff || send_on_ff) && tx_idle_i;
  always_comb begin
    if (send_off_ff) begin
      tx_flow_char_o = tx_second_ff ? chars_ff.stop_second : chars_ff.stop_first;
    end else begin
      tx_flow_char_o = tx_second_ff ? chars_ff.resume_second : chars_ff.resume_first;
    end
  end

  // data loads only at character boundary when not halted
  assign tx_go_o = tx_idle_i && !xoff_ff && !(auto_cts && cts_n_i) &&
                   !send_off_ff && !send_on_ff;

  always_comb begin
    interrupt_status_reg_o = 8'h00;
    interrupt_status_reg_o[`UAFC_STAT_XOFF]   = (xoff_ff && interrupt_enable_reg_i[`UAFC_IEN_XOFF]) || special_ff;
    interrupt_status_reg_o[`UAFC_STAT_RTSCTS] = rtscts_ff;
  end
  assign irq_o = |interrupt_status_reg_o || rx_data_irq_o;

  property p_chars_reset;
    @(posedge clk_i) $rose(rst_n_i) |-> chars_ff == '0;
  endproperty
  a_chars_reset: assert property (p_chars_reset)
    else $error("character registers not cleared");

  property p_chars_write;
    @(posedge clk_i) disable iff (!rst_n_i)
    chars_we_i |=> chars_ff == $past(chars_i);
  endproperty
  a_chars_write: assert property (p_chars_write)
    else $error("character write lost");

  property p_no_tx_cts;
    @(posedge clk_i) disable iff (!rst_n_i)
    (auto_cts && cts_n_i) |-> !tx_go_o;
  endproperty
  a_no_tx_cts: assert property (p_no_tx_cts)
    else $error("transmit allowed while cts high");

  property p_stop_halt;
    @(posedge clk_i) disable iff (!rst_n_i)
    (take && stop_hit) |=> xoff_ff && !tx_go_o;
  endproperty
  a_stop_halt: assert property (p_stop_halt)
    else $error("stop match did not halt");

  property p_resume;
    @(posedge clk_i) disable iff (!rst_n_i)
    (take && resume_hit && !stop_hit) |=> !xoff_ff;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume match did not restart");

  property p_drop;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rx_valid_i && consume && !enhanced_function_reg_i[`UAFC_ENH_SPECIAL]) |-> !f_valid;
  endproperty
  a_drop: assert property (p_drop)
    else $error("flow character stored");

  property p_rts_up;
    @(posedge clk_i) disable iff (!rst_n_i)
    (auto_rts && rx_level_i >= levels_i.upper) |=> rts_hw_ff;
  endproperty
  a_rts_up: assert property (p_rts_up)
    else $error("rts not raised at upper limit");

  property p_rts_down;
    @(posedge clk_i) disable iff (!rst_n_i)
    (auto_rts && rx_level_i <= levels_i.lower && rx_level_i < levels_i.upper) |=> !rts_hw_ff;
  endproperty
  a_rts_down: assert property (p_rts_down)
    else $error("rts not lowered at lower limit");

  property p_cts_irq;
    @(posedge clk_i) disable iff (!rst_n_i)
    (auto_cts && enh && interrupt_enable_reg_i[`UAFC_IEN_CTS] && $rose(cts_n_i))
      |=> interrupt_status_reg_o[`UAFC_STAT_RTSCTS];
  endproperty
  a_cts_irq: assert property (p_cts_irq)
    else $error("cts rise not flagged");

  property p_special;
    @(posedge clk_i) disable iff (!rst_n_i)
    (take && enhanced_function_reg_i[`UAFC_ENH_SPECIAL] && m_stop2)
      |=> interrupt_status_reg_o[`UAFC_STAT_XOFF];
  endproperty
  a_special: assert property (p_special)
    else $error("special character not flagged");

  property p_flow_idle;
    @(posedge clk_i) disable iff (!rst_n_i)
    tx_flow_valid_o |-> tx_idle_i;
  endproperty
  a_flow_idle: assert property (p_flow_idle)
    else $error("flow character mid-character");

  property p_485_low;
    @(posedge clk_i) disable iff (!rst_n_i)
    (feature_control_reg_i[`UAFC_FEAT_RS485] && tx_data_avail_i) |=> !rts_n_o;
  endproperty
  a_485_low: assert property (p_485_low)
    else $error("rs485 rts not low before send");
endmodule : uafc_top

// [sim/uafc_remote.sv]
// remote serial partner: offers received characters and takes flow characters
// assumes the local block samples on the rising edge; this model changes on the falling edge
module uafc_remote (
  input  wire logic       clk_i,        // clock
  input  wire logic       rts_n_i,      // local request to send
  input  wire logic       rx_ready_i,   // local filter ready
  output logic            rx_valid_o,   // character offered
  output logic [7:0]      rx_char_o,    // character value
  input  wire logic       flow_valid_i, // flow character offered
  input  wire logic [7:0] flow_char_i,  // flow character value
  output logic            flow_ack_o    // flow character taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  logic [7:0] got[$];
  int         lag = 3;
  int         cnt = 0;
  logic       took = 1'b0;
  logic       obey = 1'b1;
  initial begin
    rx_valid_o = 1'b0;
    rx_char_o = 8'h00;
    flow_ack_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (rx_valid_o && rx_ready_i) took = 1'b1;
    if (flow_valid_i && flow_ack_o) got.push_back(flow_char_i);
  end
  always @(negedge clk_i) begin
    if (took) begin
      void'(q.pop_front());
      rx_valid_o = 1'b0;
      // released line shows no stale value
      rx_char_o = ~rx_char_o;
      took = 1'b0;
    end else if (!rx_valid_o && q.size() > 0 && (!rts_n_i || !obey)) begin
      rx_valid_o = 1'b1;
      rx_char_o = q[0];
    end
    if (flow_ack_o) flow_ack_o = 1'b0;
    else if (flow_valid_i && cnt >= lag) begin
      flow_ack_o = 1'b1;
      cnt = 0;
    end else if (flow_valid_i) cnt++;
  end
endmodule : uafc_remote

// [sim/uafc_top_bench.sv]
// self-checking bench for the automatic flow-control block
// assumes the remote partner model and a 50 MHz clock
module uafc_top_bench;
  import uafc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_i, rst_n_i, chars_we_i, rx_fifo_full_i, rx_valid_i, rx_ready_o, rxf_valid_o, rxf_ready_i;
  logic         rx_data_irq_o, cts_n_i, rts_n_o, tx_data_avail_i, tx_idle_i, tx_go_o, tx_flow_valid_o;
  logic         tx_flow_ack_i, stop_flag_o, irq_o;
  logic [7:0]   enh_fn, int_en, modem_ctl, feat_ctl, rx_level_i, rx_char_i, rxf_data_o, tx_flow_char_o, int_stat;
  logic [1:0]   word_len_i;
  uafc_swmode_t rx_mode, tx_mode;
  uafc_chars_t  chars_i, chars_o;
  uafc_levels_t levels_i;
  logic [7:0]   rxq[$];
  int           miscompares = 0;
  int           total_checks = 0;

  uafc_top #(.BIT_CLKS(1)) DUT (.clk_i, .rst_n_i, .enhanced_function_reg_i(enh_fn),
    .interrupt_enable_reg_i(int_en), .modem_control_reg_i(modem_ctl), .feature_control_reg_i(feat_ctl),
    .word_len_i, .rx_sw_mode_i(rx_mode),
    .tx_sw_mode_i(tx_mode), .chars_we_i, .chars_i, .chars_o, .levels_i, .rx_level_i, .rx_fifo_full_i,
    .rx_valid_i, .rx_char_i, .rx_ready_o, .rxf_valid_o, .rxf_ready_i, .rxf_data_o, .rx_data_irq_o,
    .cts_n_i, .rts_n_o, .tx_data_avail_i, .tx_idle_i, .tx_go_o, .tx_flow_valid_o, .tx_flow_char_o,
    .tx_flow_ack_i, .stop_flag_o, .interrupt_status_reg_o(int_stat), .irq_o);

  uafc_remote far (.clk_i, .rts_n_i(rts_n_o), .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i),
    .rx_char_o(rx_char_i), .flow_valid_i(tx_flow_valid_o), .flow_char_i(tx_flow_char_o),
    .flow_ack_o(tx_flow_ack_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (rxf_valid_o && rxf_ready_i && !rx_fifo_full_i) rxq.push_back(rxf_data_o);

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wt

  // hand one character to the partner and wait until it is taken
  task send(input logic [7:0] ch);
    int i;
    far.q.push_back(ch);
    for (i = 0; i < 60 && !far.took; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (!far.took) begin
      chk(32'h0000_0000, 32'h0000_0001);
      test_done();
    end
    wt(3);
  endtask : send

  task wait_flow(input int n, input int bound);
    int i;
    for (i = 0; i < bound && far.got.size() < n; i++) wt(1);
    if (far.got.size() < n) begin
      chk(32'h0000_0000, 32'h0000_0001);
      test_done();
    end
  endtask : wait_flow

  initial begin
    rst_n_i = 1'b0;
    enh_fn = 8'h00;
    int_en = 8'h00;
    modem_ctl = 8'h00;
    feat_ctl = 8'h00;
    word_len_i = 2'h3;
    rx_mode = UAFC_SW_NONE;
    tx_mode = UAFC_SW_NONE;
    chars_we_i = 1'b0;
    chars_i = 32'h0000_0000;
    levels_i = 24'h04_080C;
    rx_level_i = 8'h00;
    rx_fifo_full_i = 1'b0;
    rxf_ready_i = 1'b1;
    cts_n_i = 1'b0;
    tx_data_avail_i = 1'b1;
    tx_idle_i = 1'b1;
    wt(3);
    rst_n_i = 1'b1;
    wt(1);
    chk(chars_o, 32'h0000_0000);
    chk(rts_n_o, 1'b1);
    chk(stop_flag_o, 1'b0);
    modem_ctl = 8'h02;
    chars_we_i = 1'b1;
    chars_i = 32'h1393_1191;
    wt(1);
    chars_we_i = 1'b0;
    rx_level_i = 8'h0C;
    wt(2);
    chk(chars_o, 32'h1393_1191);
    chk(rts_n_o, 1'b0);
    enh_fn = 8'h50;
    int_en = 8'h40;
    rx_level_i = 8'h08;
    wt(2);
    chk(rts_n_o, 1'b0);
    chk(rx_data_irq_o, 1'b1);
    rx_level_i = 8'h0B;
    wt(2);
    chk(rts_n_o, 1'b0);
    chk(int_stat[5], 1'b0);
    rx_level_i = 8'h0C;
    wt(2);
    chk(rts_n_o, 1'b1);
    chk(int_stat[5], 1'b1);
    chk(irq_o, 1'b1);
    far.obey = 1'b0;
    send(8'h41);
    far.obey = 1'b1;
    chk(rxq.size(), 1);
    rx_level_i = 8'h05;
    wt(2);
    chk(rts_n_o, 1'b1);
    rx_level_i = 8'h04;
    wt(2);
    chk(rts_n_o, 1'b0);
    chk(rx_data_irq_o, 1'b0);
    rx_level_i = 8'h00;
    enh_fn = 8'h90;
    int_en = 8'h80;
    cts_n_i = 1'b1;
    wt(2);
    chk(tx_go_o, 1'b0);
    chk(int_stat[5], 1'b1);
    chk(irq_o, 1'b1);
    cts_n_i = 1'b0;
    wt(2);
    chk(tx_go_o, 1'b1);
    enh_fn = 8'h10;
    cts_n_i = 1'b1;
    wt(2);
    chk(tx_go_o, 1'b1);
    cts_n_i = 1'b0;
    rxq.delete();
    enh_fn = 8'h30;
    send(8'h93);
    chk(rxq.size(), 1);
    chk(rxq[0], 8'h93);
    chk(int_stat[4], 1'b1);
    rxq.delete();
    enh_fn = 8'h10;
    int_en = 8'h20;
    rx_mode = UAFC_SW_SINGLE;
    send(8'h93);
    chk(stop_flag_o, 1'b0);
    send(8'h13);
    chk(stop_flag_o, 1'b1);
    chk(tx_go_o, 1'b0);
    chk(irq_o, 1'b1);
    send(8'h11);
    chk(stop_flag_o, 1'b0);
    chk(int_stat[4], 1'b0);
    chk(tx_go_o, 1'b1);
    chk(rxq.size(), 1);
    chk(rxq[0], 8'h93);
    word_len_i = 2'h0;
    send(8'hF3);
    chk(stop_flag_o, 1'b1);
    send(8'hF1);
    chk(stop_flag_o, 1'b0);
    word_len_i = 2'h3;
    send(8'hF3);
    chk(stop_flag_o, 1'b0);
    rx_mode = UAFC_SW_DOUBLE;
    send(8'h13);
    send(8'h41);
    chk(stop_flag_o, 1'b0);
    send(8'h13);
    send(8'h93);
    chk(stop_flag_o, 1'b1);
    send(8'h11);
    send(8'h91);
    chk(stop_flag_o, 1'b0);
    rx_mode = UAFC_SW_NONE;
    // fill the small fifo until it refuses, then drain
    rxq.delete();
    rxf_ready_i = 1'b0;
    for (int i = 0; i < 4; i++) send(8'h41 + i[7:0]);
    far.q.push_back(8'h45);
    wt(10);
    chk(rx_ready_o, 1'b0);
    chk(far.q.size(), 1);
    rx_fifo_full_i = 1'b1;
    rxf_ready_i = 1'b1;
    wt(5);
    chk(rxq.size(), 0);
    rx_fifo_full_i = 1'b0;
    wt(20);
    chk(rxq.size(), 5);
    for (int i = 0; i < 5; i++) chk(rxq[i], 8'h41 + i[7:0]);
    tx_mode = UAFC_SW_SINGLE;
    tx_idle_i = 1'b0;
    rx_level_i = 8'h08;
    wt(30);
    chk(tx_flow_valid_o, 1'b0);
    tx_idle_i = 1'b1;
    wait_flow(1, 40);
    chk(far.got[0], 8'h13);
    rx_level_i = 8'h04;
    wt(6);
    chk(far.got.size(), 1);
    rx_level_i = 8'h03;
    wait_flow(2, 40);
    chk(far.got[1], 8'h11);
    far.got.delete();
    tx_mode = UAFC_SW_DOUBLE;
    rx_level_i = 8'h08;
    wt(18);
    chk(tx_flow_valid_o, 1'b0);
    wait_flow(2, 40);
    chk(far.got[0], 8'h13);
    chk(far.got[1], 8'h93);
    rx_level_i = 8'h00;
    wait_flow(4, 40);
    chk(far.got[2], 8'h11);
    chk(far.got[3], 8'h91);
    tx_mode = UAFC_SW_NONE;
    feat_ctl = 8'h08;
    tx_idle_i = 1'b0;
    tx_data_avail_i = 1'b0;
    wt(2);
    chk(rts_n_o, 1'b0);
    tx_idle_i = 1'b1;
    wt(2);
    chk(rts_n_o, 1'b1);
    tx_data_avail_i = 1'b1;
    wt(1);
    chk(rts_n_o, 1'b0);
    test_done();
  end
endmodule : uafc_top_bench
